// ### verilog/tcsar_pkg.sv
/*
 * Constants for the timer clock select and auto-reload timer block:
 * register addresses, field positions, reset values and divider counts.
 * Assumes an 8-bit special function register bus from the processor core.
 */
package tcsar_pkg;
    // ********************************************************
    // Register addresses
    // ********************************************************
    localparam logic [7:0] ADDR_TIMER0_COUNT_LOW = 8'h8a;
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8e;
    localparam logic [7:0] ADDR_T2_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_T2_RELOAD_LOW = 8'hca;
    localparam logic [7:0] ADDR_T2_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_T2_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_T2_COUNT_HIGH = 8'hcd;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CK_T2_HIGH_SEL = 6;
    localparam int CK_T2_LOW_SEL = 5;
    localparam int CK_T1_SEL = 4;
    localparam int CK_T0_SEL = 3;
    localparam int T2_HIGH_FLAG = 7;
    localparam int T2_LOW_FLAG = 6;
    localparam int T2_LOW_IRQ_EN = 5;
    localparam int T2_SPLIT = 3;
    localparam int T2_RUN = 2;
    localparam int T2_EXT_SEL = 0;

    // Writable bits; others read as zero
    localparam logic [7:0] CK_WRITE_MASK = 8'h7b;
    localparam logic [7:0] T2_WRITE_MASK = 8'hed;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ********************************************************
    // Prescaler settings and divider counts
    // ********************************************************
    localparam logic [1:0] PRE_DIV12 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    localparam logic [1:0] PRE_DIV48 = 2'h2;
    localparam logic [1:0] PRE_EXT8 = 2'h3;
    localparam logic [5:0] DIV48_LAST = 6'h2f;
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [2:0] EXT8_LAST = 3'h7;
    localparam logic [7:0] BYTE_MAX = 8'hff;
endpackage : tcsar_pkg

// ### verilog/tcsar_top.sv
/*
 * Timer clock selection and 16-bit auto-reload timer (one or two 8-bit).
 * Assumes a processor core on the special function register bus, one
 * system clock, and an external oscillator no faster than that clock.
 */
// Function
// RULE_01: Timer 1 ticks on prescaler when select 0, system clock when 1.
// RULE_02: Timer 0 ticks on prescaler when select 0, system clock when 1.
// RULE_03: Clock control bit 2 reads zero and ignores writes.
// RULE_04: Prescale 10 gives clock over 48, 11 gives external over 8.
// RULE_05: Prescale 00 gives clock over 12, 01 gives clock over 4.
// RULE_06: External clock over 8 is synchronised before it advances counters.
// RULE_07: External clock must be no faster than the system clock.
// RULE_08: Timer is two 8-bit counters, one 16-bit or two 8-bit.
// RULE_09: Control bit 3 selects 16-bit (0) or split 8-bit (1).
// RULE_10: 16-bit overflow from ffff loads both reload bytes.
// RULE_11: 16-bit overflow sets the high overflow flag.
// RULE_12: Enabled interrupt fires on every 16-bit overflow.
// RULE_13: With low enable, low byte overflow also interrupts in 16-bit mode.
// RULE_14: 16-bit counter clocks from clock, clock over 12 or external over 8.
// RULE_15: Low clock select drives whole counter, or low half when split.
// RULE_16: High clock select only matters in split mode.
// RULE_17: Split halves each reload from their own reload byte.
// RULE_18: Split mode run bit gates only the high counter.
// RULE_19: Split clock: select 1 system, else over 12 or external over 8.
// RULE_20: Split wraps set high flag and low flag respectively.
// RULE_21: Split high overflow interrupts; low too when low enable set.
// RULE_22: Handler reads both flags to find the interrupt source.
// RULE_23: Flags are cleared only by software writes.
`timescale 1ns/100ps
module tcsar_top
    import tcsar_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    input wire logic EXT_CLK,
    input wire logic T2_IRQ_ENABLE,
    input wire logic TIMER0_COUNTER_MODE,
    input wire logic TIMER1_COUNTER_MODE,
    output logic TIMER0_TICK,
    output logic TIMER1_TICK,
    output logic T2_IRQ
);
    // ********************************************************
    // Register state
    // ********************************************************
    // Every _reg takes its _next from one always_comb
    // Synchroniser flops only shift, so they have no _next
    logic [7:0] ck_reg, ck_next;
    logic [7:0] t2c_reg, t2c_next;
    logic [7:0] rll_reg, rll_next;
    logic [7:0] rlh_reg, rlh_next;
    logic [7:0] cnt_l_reg, cnt_l_next;
    logic [7:0] cnt_h_reg, cnt_h_next;
    logic [7:0] t0l_reg, t0l_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [5:0] pre_reg, pre_next;
    logic [3:0] d12_reg, d12_next;
    logic [2:0] e8_reg, e8_next;
    logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
    logic t0_reg, t0_next;
    logic t1_reg, t1_next;
    logic irq_reg, irq_next;

    // Decoded strobes and ticks
    logic wr_ck, wr_t2c, wr_rll, wr_rlh, wr_cl, wr_ch, wr_t0l;
    logic tick4, tick12, tick48, ext_edge, tick_ext8;
    logic pre_tick, low_tick, high_tick;
    logic split, run, low_ovf, high_ovf;

    // Select one of system clock, clock over 12 or external over 8
    // Shared by both halves so their source muxes cannot drift apart
    function automatic logic t2_source(input logic sys_sel, input logic ext_sel,
                                        input logic t12, input logic te8);
        t2_source = sys_sel ? 1'b1 : (ext_sel ? te8 : t12);
    endfunction : t2_source

    // Write strobe for one address
    // Decoding used by every writable register
    function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target,
                                    input logic wr);
        wr_hit = wr && (addr == target);
    endfunction : wr_hit

    // ********************************************************
    // Bus decode
    // ********************************************************
    // One write strobe per mapped register
    // Read decode sits with the read data mux below
    always_comb begin
        wr_ck = wr_hit(SFR_ADDR, ADDR_CLOCK_CONTROL, SFR_WR);
        wr_t2c = wr_hit(SFR_ADDR, ADDR_T2_CONTROL, SFR_WR);
        wr_rll = wr_hit(SFR_ADDR, ADDR_T2_RELOAD_LOW, SFR_WR);
        wr_rlh = wr_hit(SFR_ADDR, ADDR_T2_RELOAD_HIGH, SFR_WR);
        wr_cl = wr_hit(SFR_ADDR, ADDR_T2_COUNT_LOW, SFR_WR);
        wr_ch = wr_hit(SFR_ADDR, ADDR_T2_COUNT_HIGH, SFR_WR);
        wr_t0l = wr_hit(SFR_ADDR, ADDR_TIMER0_COUNT_LOW, SFR_WR);
    end

    // ********************************************************
    // External clock synchroniser
    // ********************************************************
    // Two flops then an edge detector on the settled copy
    // EXT_CLK is asynchronous; the first flop feeds only the second
    // Third flop holds the last settled level for edge detection
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end else begin
            ext_s1_reg <= EXT_CLK; // RULE_06
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    // ********************************************************
    // Prescalers
    // ********************************************************
    // Divider counts and selected prescaler tick
    // Dividers run free; a select change does not restart them
    // So the first tick after a select change may come early
    // The /4 tick reuses the /48 counter, 48 being a multiple of 4
    // Pin must be slower than the system clock or edges are lost
    always_comb begin
        ext_edge = ext_s2_reg && !ext_s3_reg;
        tick48 = (pre_reg == DIV48_LAST);
        tick4 = (pre_reg[1:0] == DIV4_LAST);
        tick12 = (d12_reg == DIV12_LAST);
        tick_ext8 = ext_edge && (e8_reg == EXT8_LAST); // RULE_06
        pre_next = tick48 ? 6'h00 : pre_reg + 6'h01;
        d12_next = tick12 ? 4'h0 : d12_reg + 4'h1;
        e8_next = ext_edge ? e8_reg + 3'h1 : e8_reg;
        // Shared prescale for Timer 0 and Timer 1
        case (ck_reg[1:0])
            PRE_DIV12: pre_tick = tick12; // RULE_05
            PRE_DIV4: pre_tick = tick4; // RULE_05
            PRE_DIV48: pre_tick = tick48; // RULE_04
            PRE_EXT8: pre_tick = tick_ext8; // RULE_04
            default: pre_tick = 1'b0;
        endcase
        // Counter mode takes its clock elsewhere, so no tick here
        t0_next = !TIMER0_COUNTER_MODE && (ck_reg[CK_T0_SEL] || pre_tick); // RULE_02
        t1_next = !TIMER1_COUNTER_MODE && (ck_reg[CK_T1_SEL] || pre_tick); // RULE_01
    end

    // Register prescaler state
    // Tick outputs land one cycle after the internal tick
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            pre_reg <= 6'h00;
            d12_reg <= 4'h0;
            e8_reg <= 3'h0;
            t0_reg <= 1'b0;
            t1_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            d12_reg <= d12_next;
            e8_reg <= e8_next;
            t0_reg <= t0_next;
            t1_reg <= t1_next;
        end
    end

    // ********************************************************
    // Auto-reload timer
    // ********************************************************
    // Clock choice, counting, reload and flags
    // Low select clocks the whole counter unless split
    always_comb begin
        split = t2c_reg[T2_SPLIT]; // RULE_09
        run = t2c_reg[T2_RUN];
        low_tick = t2_source(ck_reg[CK_T2_LOW_SEL], t2c_reg[T2_EXT_SEL],
                             tick12, tick_ext8); // RULE_14 RULE_15 RULE_19
        high_tick = t2_source(ck_reg[CK_T2_HIGH_SEL], t2c_reg[T2_EXT_SEL],
                              tick12, tick_ext8); // RULE_16 RULE_19
        // Default: counts hold, no overflow
        cnt_l_next = cnt_l_reg;
        cnt_h_next = cnt_h_reg;
        low_ovf = 1'b0;
        high_ovf = 1'b0;
        if (split) begin
            // Low half free-running, high half gated by run
            if (low_tick) begin // RULE_18
                low_ovf = (cnt_l_reg == BYTE_MAX);
                cnt_l_next = low_ovf ? rll_reg : cnt_l_reg + 8'h01; // RULE_17
            end
            if (run && high_tick) begin // RULE_18
                high_ovf = (cnt_h_reg == BYTE_MAX);
                cnt_h_next = high_ovf ? rlh_reg : cnt_h_reg + 8'h01; // RULE_17
            end
        end else if (run && low_tick) begin // RULE_08
            // Low carries into high; both reload at ffff
            low_ovf = (cnt_l_reg == BYTE_MAX);
            high_ovf = low_ovf && (cnt_h_reg == BYTE_MAX);
            if (high_ovf) begin
                cnt_l_next = rll_reg; // RULE_10
                cnt_h_next = rlh_reg; // RULE_10
            end else begin
                cnt_l_next = cnt_l_reg + 8'h01;
                cnt_h_next = low_ovf ? cnt_h_reg + 8'h01 : cnt_h_reg;
            end
        end
        // Software writes to the count bytes take precedence
        // A write on an overflow edge drops that reload
        if (wr_cl) begin
            cnt_l_next = SFR_WDATA;
        end
        if (wr_ch) begin
            cnt_h_next = SFR_WDATA;
        end
        // Control: software writes, hardware set wins over clear
        // Low flag sets in both modes; no hardware path clears a flag
        t2c_next = wr_t2c ? (SFR_WDATA & T2_WRITE_MASK) : t2c_reg;
        if (high_ovf) begin
            t2c_next[T2_HIGH_FLAG] = 1'b1; // RULE_11 RULE_20 RULE_23
        end
        if (low_ovf) begin
            t2c_next[T2_LOW_FLAG] = 1'b1; // RULE_20 RULE_23
        end
        // Request is a level held until software clears the flag
        // With low requests on, the handler must read both flags
        irq_next = T2_IRQ_ENABLE && (t2c_reg[T2_HIGH_FLAG]
                   || (t2c_reg[T2_LOW_IRQ_EN] && t2c_reg[T2_LOW_FLAG])); // RULE_12 RULE_13 RULE_21
    end

    // Register timer state
    // Counts change on ticks and writes; flags keep their value until written
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            t2c_reg <= RESET_BYTE;
            cnt_l_reg <= RESET_BYTE;
            cnt_h_reg <= RESET_BYTE;
            irq_reg <= 1'b0;
        end else begin
            t2c_reg <= t2c_next;
            cnt_l_reg <= cnt_l_next;
            cnt_h_reg <= cnt_h_next;
            irq_reg <= irq_next;
        end
    end

    // ********************************************************
    // Plain registers and read path
    // ********************************************************
    // Stored bytes and registered read data
    // Count bytes are not latched, so a 16-bit read may tear
    // Unused control bits are masked on write and read zero
    always_comb begin
        ck_next = wr_ck ? (SFR_WDATA & CK_WRITE_MASK) : ck_reg; // RULE_03
        rll_next = wr_rll ? SFR_WDATA : rll_reg;
        rlh_next = wr_rlh ? SFR_WDATA : rlh_reg;
        t0l_next = wr_t0l ? SFR_WDATA : t0l_reg;
        // Read data holds between reads
        rdata_next = rdata_reg;
        if (SFR_RD) begin
            case (SFR_ADDR)
                ADDR_CLOCK_CONTROL: rdata_next = ck_reg; // RULE_03
                ADDR_T2_CONTROL: rdata_next = t2c_reg; // RULE_22
                ADDR_T2_RELOAD_LOW: rdata_next = rll_reg;
                ADDR_T2_RELOAD_HIGH: rdata_next = rlh_reg;
                ADDR_T2_COUNT_LOW: rdata_next = cnt_l_reg;
                ADDR_T2_COUNT_HIGH: rdata_next = cnt_h_reg;
                ADDR_TIMER0_COUNT_LOW: rdata_next = t0l_reg;
                default: rdata_next = RESET_BYTE;
            endcase
        end
    end

    // Register stored bytes
    // Plain storage for timer0_count_low; Timer 0 counts elsewhere
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ck_reg <= RESET_BYTE;
            rll_reg <= RESET_BYTE;
            rlh_reg <= RESET_BYTE;
            t0l_reg <= RESET_BYTE;
            rdata_reg <= RESET_BYTE;
        end else begin
            ck_reg <= ck_next;
            rll_reg <= rll_next;
            rlh_reg <= rlh_next;
            t0l_reg <= t0l_next;
            rdata_reg <= rdata_next;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // All outputs straight from flip-flops
    assign SFR_RDATA = rdata_reg;
    assign TIMER0_TICK = t0_reg;
    assign TIMER1_TICK = t1_reg;
    assign T2_IRQ = irq_reg;
endmodule : tcsar_top

// ### tb/tcsar_top_monitor.sv
/* Port checker for tcsar_top, attached by bind.
   Assumes one clock domain and the register map of tcsar_pkg. */
`timescale 1ns/100ps
module tcsar_top_monitor
    import tcsar_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic T2_IRQ_ENABLE,
    input wire logic TIMER0_COUNTER_MODE,
    input wire logic TIMER1_COUNTER_MODE,
    input wire logic TIMER0_TICK,
    input wire logic TIMER1_TICK,
    input wire logic T2_IRQ
);
    // ********
    // Clock control shadow and tick spacing
    // ********
    logic [7:0] ck_reg;
    logic [7:0] age_reg;
    logic [7:0] gap_reg;
    logic [7:0] exp_gap;
    logic ctl_wr;
    logic mapped;
    logic settled;
    assign ctl_wr = SFR_WR && SFR_ADDR == ADDR_T2_CONTROL;
    assign mapped = SFR_ADDR inside {ADDR_TIMER0_COUNT_LOW, ADDR_CLOCK_CONTROL, ADDR_T2_CONTROL,
        ADDR_T2_RELOAD_LOW, ADDR_T2_RELOAD_HIGH, ADDR_T2_COUNT_LOW, ADDR_T2_COUNT_HIGH};
    assign settled = age_reg > 8'h64 && !ck_reg[CK_T1_SEL] && ck_reg[1:0] != PRE_EXT8
        && !TIMER1_COUNTER_MODE;
    assign exp_gap = ck_reg[1:0] == PRE_DIV12 ? 8'(DIV12_LAST)
        : ck_reg[1:0] == PRE_DIV4 ? 8'(DIV4_LAST) : 8'(DIV48_LAST);
    // Shadow, cycles since its write, cycles since last tick
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ck_reg <= 8'h00;
            age_reg <= 8'h00;
            gap_reg <= 8'h00;
        end else begin
            if (SFR_WR && SFR_ADDR == ADDR_CLOCK_CONTROL) begin
                ck_reg <= SFR_WDATA & CK_WRITE_MASK;
                age_reg <= 8'h00;
            end else if (age_reg != 8'hff) begin
                age_reg <= age_reg + 8'h01;
            end
            gap_reg <= TIMER1_TICK ? 8'h00 : gap_reg + 8'h01;
        end
    end
    // ********
    // Assertions
    // ********
    default clocking mon_cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);
    t1_sys_level_a: assert property ((ck_reg[CK_T1_SEL] && !TIMER1_COUNTER_MODE
        && age_reg > 8'h03) [*3] |-> TIMER1_TICK) else $error("timer1 tick not steady");
    t0_sys_level_a: assert property ((ck_reg[CK_T0_SEL] && !TIMER0_COUNTER_MODE
        && age_reg > 8'h03) [*3] |-> TIMER0_TICK) else $error("timer0 tick not steady");
    t0_mode_gate_a: assert property (TIMER0_COUNTER_MODE [*3] |-> !TIMER0_TICK)
        else $error("timer0 tick in counter mode");
    ck_unused_zero_a: assert property (SFR_RD && SFR_ADDR == ADDR_CLOCK_CONTROL
        |=> (SFR_RDATA & ~CK_WRITE_MASK) == 8'h00) else $error("unused clock bits set");
    prescale_period_a: assert property (TIMER1_TICK && settled |-> gap_reg == exp_gap)
        else $error("prescaled tick spacing wrong");
    irq_needs_ie_a: assert property (!T2_IRQ_ENABLE |=> !T2_IRQ)
        else $error("interrupt without enable");
    flag_hold_a: assert property (T2_IRQ && T2_IRQ_ENABLE && !$past(ctl_wr) |=> T2_IRQ)
        else $error("interrupt dropped without clear");
    unmapped_zero_a: assert property (SFR_RD && !mapped |=> SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!SFR_RD |=> $stable(SFR_RDATA))
        else $error("read data moved without read");
    // Main scenarios reached
    irq_seen_c: cover property ($rose(T2_IRQ));
    div48_seen_c: cover property (TIMER1_TICK && settled && ck_reg[1:0] == PRE_DIV48);
    unmapped_seen_c: cover property (SFR_RD && !mapped);
endmodule : tcsar_top_monitor

bind tcsar_top tcsar_top_monitor mon (.SYS_CLK(SYS_CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
    .T2_IRQ_ENABLE(T2_IRQ_ENABLE), .TIMER0_COUNTER_MODE(TIMER0_COUNTER_MODE),
    .TIMER1_COUNTER_MODE(TIMER1_COUNTER_MODE), .TIMER0_TICK(TIMER0_TICK),
    .TIMER1_TICK(TIMER1_TICK), .T2_IRQ(T2_IRQ));

// ### tb/tcsar_core_model.sv
/* Processor core model: register bus accesses and the timer interrupt handler.
   Assumes strobes are sampled on the rising clock edge. */
`timescale 1ns/100ps
module tcsar_core_model
    import tcsar_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic [7:0] SFR_RDATA,
    output logic [7:0] SFR_ADDR,
    output logic [7:0] SFR_WDATA,
    output logic SFR_WR,
    output logic SFR_RD,
    output logic T2_IRQ_ENABLE
);
    // ********
    // Bus cycles
    // ********
    initial begin
        SFR_ADDR = 8'h00;
        SFR_WDATA = 8'h00;
        SFR_WR = 1'b0;
        SFR_RD = 1'b0;
        T2_IRQ_ENABLE = 1'b0;
    end
    // One write; released lines show the inverse, not a stale value
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge SYS_CLK);
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WR = 1'b1;
        @(negedge SYS_CLK);
        SFR_WR = 1'b0;
        SFR_ADDR = ~a;
        SFR_WDATA = ~d;
    endtask : sfr_write
    // One read; data taken a cycle after the read edge
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge SYS_CLK);
        SFR_ADDR = a;
        SFR_RD = 1'b1;
        @(negedge SYS_CLK);
        SFR_RD = 1'b0;
        SFR_ADDR = ~a;
        @(negedge SYS_CLK);
        d = SFR_RDATA;
    endtask : sfr_read
    // Handler reads both flags, then clears them itself
    task automatic isr(output logic [7:0] flags);
        sfr_read(ADDR_T2_CONTROL, flags);
        sfr_write(ADDR_T2_CONTROL, flags & 8'h3f);
    endtask : isr
    // Interrupt enable bit of the core
    task automatic irq_enable(input logic e);
        T2_IRQ_ENABLE = e;
    endtask : irq_enable
endmodule : tcsar_core_model

// ### tb/tcsar_top_tb.sv
/* Self-checking bench for tcsar_top with the core model on its register bus.
   Assumes a 25 MHz system clock and a slower free-running external clock. */
`timescale 1ns/100ps
module tcsar_top_tb;
    import tcsar_pkg::*;
    // ********
    // Signals, rows and checks
    // ********
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} tcsar_row_t;
    logic sys_clk, nrst, ext_clk, wr, rd, ie, mode0, mode1, tick0, tick1, irq;
    logic [7:0] addr, wdata, rdata, v;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    tcsar_row_t rows[7] = '{'{ADDR_TIMER0_COUNT_LOW, 8'h5a, 8'h5a}, '{ADDR_CLOCK_CONTROL, 8'hff, 8'h7b},
        '{ADDR_T2_CONTROL, 8'h12, 8'h00}, '{ADDR_T2_RELOAD_LOW, 8'ha5, 8'ha5},
        '{ADDR_T2_RELOAD_HIGH, 8'h3c, 8'h3c}, '{ADDR_T2_COUNT_HIGH, 8'h77, 8'h77},
        '{8'h80, 8'hff, 8'h00}};
    logic [7:0] periods[4] = '{8'h0c, 8'h04, 8'h30, 8'h18};
    tcsar_core_model core (.SYS_CLK(sys_clk), .SFR_RDATA(rdata), .SFR_ADDR(addr),
        .SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .T2_IRQ_ENABLE(ie));
    tcsar_top dut (.SYS_CLK(sys_clk), .NRST(nrst), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .EXT_CLK(ext_clk), .T2_IRQ_ENABLE(ie),
        .TIMER0_COUNTER_MODE(mode0), .TIMER1_COUNTER_MODE(mode1), .TIMER0_TICK(tick0),
        .TIMER1_TICK(tick1), .T2_IRQ(irq));
    task automatic check8(input string what, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask : check8
    task automatic check1(input string what, input logic e, input logic s);
        check8(what, {7'h00, e}, {7'h00, s});
    endtask : check1
    task automatic print_verdict;
        if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    // Cycles between two Timer 1 ticks, bounded
    task automatic tick_gap(output int g);
        int k;
        k = 0;
        while (tick1 !== 1'b1 && k < 200) begin
            @(negedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
        g = 1;
        while (tick1 !== 1'b1 && g < 200) begin
            @(negedge sys_clk);
            g++;
        end
    endtask : tick_gap
    // ********
    // Clocks, watchdog, sequence
    // ********
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // External clock at a third of the system rate, own phase
    initial begin
        ext_clk = 1'b0;
        #7;
        forever #60 ext_clk = ~ext_clk;
    end
    initial begin
        #400000;
        fail_count++;
        print_verdict();
    end
    initial begin
        nrst = 1'b0;
        mode0 = 1'b0;
        mode1 = 1'b0;
        repeat (4) @(negedge sys_clk);
        nrst = 1'b1;
        foreach (rows[i]) begin
            core.sfr_write(rows[i].a, rows[i].d);
            core.sfr_read(rows[i].a, v);
            check8("register", rows[i].e, v);
        end
        // Reset in mid-run
        nrst = 1'b0;
        repeat (4) @(negedge sys_clk);
        check1("tick0 in reset", 1'b0, tick0);
        nrst = 1'b1;
        core.sfr_read(ADDR_CLOCK_CONTROL, v);
        check8("clock control reset", 8'h00, v);
        for (int p = 0; p < 4; p++) begin
            core.sfr_write(ADDR_CLOCK_CONTROL, 8'(p));
            repeat (3) tick_gap(n);
            check8("prescale period", periods[p], 8'(n));
        end
        core.sfr_write(ADDR_CLOCK_CONTROL, 8'h18);
        mode0 = 1'b1;
        repeat (6) @(negedge sys_clk);
        check1("tick0 counter mode", 1'b0, tick0);
        check1("tick1 system clock", 1'b1, tick1);
        mode0 = 1'b0;
        mode1 = 1'b1;
        repeat (6) @(negedge sys_clk);
        check1("tick0 system clock", 1'b1, tick0);
        check1("tick1 counter mode", 1'b0, tick1);
        mode1 = 1'b0;
        // Split mode, high half stopped, low half on system clock
        core.irq_enable(1'b1);
        core.sfr_write(ADDR_CLOCK_CONTROL, 8'h20);
        core.sfr_write(ADDR_T2_RELOAD_LOW, 8'hf0);
        core.sfr_write(ADDR_T2_COUNT_HIGH, 8'h40);
        core.sfr_write(ADDR_T2_COUNT_LOW, 8'hfe);
        core.sfr_write(ADDR_T2_CONTROL, 8'h28);
        repeat (40) @(negedge sys_clk);
        core.sfr_read(ADDR_T2_COUNT_HIGH, v);
        check8("high held", 8'h40, v);
        core.sfr_read(ADDR_T2_COUNT_LOW, v);
        check1("low reloaded", 1'b1, v >= 8'hf0);
        core.sfr_read(ADDR_T2_CONTROL, v);
        check8("low flag only", 8'h68, v);
        check1("low irq", 1'b1, irq);
        core.sfr_write(ADDR_CLOCK_CONTROL, 8'h60);
        core.sfr_write(ADDR_T2_RELOAD_HIGH, 8'h80);
        core.sfr_write(ADDR_T2_COUNT_HIGH, 8'hfe);
        core.sfr_write(ADDR_T2_CONTROL, 8'h2c);
        repeat (10) @(negedge sys_clk);
        core.sfr_read(ADDR_T2_CONTROL, v);
        check1("high flag split", 1'b1, v[T2_HIGH_FLAG]);
        core.sfr_read(ADDR_T2_COUNT_HIGH, v);
        check1("high reloaded", 1'b1, v >= 8'h80);
        // 16-bit mode, interrupts masked first
        core.irq_enable(1'b0);
        core.sfr_write(ADDR_T2_CONTROL, 8'h00);
        core.sfr_write(ADDR_CLOCK_CONTROL, 8'h20);
        core.sfr_write(ADDR_T2_RELOAD_HIGH, 8'h12);
        core.sfr_write(ADDR_T2_RELOAD_LOW, 8'h34);
        core.sfr_write(ADDR_T2_COUNT_HIGH, 8'hff);
        core.sfr_write(ADDR_T2_COUNT_LOW, 8'hf8);
        core.sfr_write(ADDR_T2_CONTROL, 8'h04);
        repeat (30) @(negedge sys_clk);
        check1("masked irq", 1'b0, irq);
        core.sfr_read(ADDR_T2_COUNT_HIGH, v);
        check8("16-bit reload", 8'h12, v);
        core.sfr_read(ADDR_T2_CONTROL, v);
        check1("high flag 16-bit", 1'b1, v[T2_HIGH_FLAG]);
        core.irq_enable(1'b1);
        repeat (3) @(negedge sys_clk);
        check1("16-bit irq", 1'b1, irq);
        core.isr(v);
        repeat (3) @(negedge sys_clk);
        check1("irq cleared", 1'b0, irq);
        core.sfr_write(ADDR_T2_CONTROL, 8'h24);
        repeat (300) @(negedge sys_clk);
        check1("low byte irq", 1'b1, irq);
        // High select ignored outside split: low select 0 gives over 12
        core.sfr_write(ADDR_CLOCK_CONTROL, 8'h40);
        core.sfr_write(ADDR_T2_COUNT_LOW, 8'h00);
        repeat (24) @(negedge sys_clk);
        core.sfr_read(ADDR_T2_COUNT_LOW, v);
        check1("slow 16-bit clock", 1'b1, v < 8'h05);
        print_verdict();
    end
endmodule : tcsar_top_tb
